/* src/fses_top.v */
// Suspend and fault flag tracker with its AXI4-Lite register slave
//
// Design decisions made here: register access over AXI4-Lite and the register offsets.
`include "fses_regs.vh"

module fses_top #(
    parameter ADDR_W = 4
) (
    // Clock, reset, enable
    input wire aclk,
    input wire aresetn,
    input wire ce,
    // Accepted commands from the serial decoder
    input wire cmd_valid,
    input wire [7:0] cmd_opcode,
    // Array engine events
    input wire op_done,
    input wire op_error,
    // Any external device reset, one-cycle pulse
    input wire dev_reset,
    // AXI4-Lite write address
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Status outputs
    output reg busy_q,
    output reg suspend_summary_flag,
    output reg erase_held_flag,
    output reg program_held_flag,
    output reg erase_fault_flag,
    output reg program_fault_flag,
    output reg light_power_down_state,
    output reg ultra_power_down_state
);

    // ----------------------------------------
    // Command classes
    // ----------------------------------------
    reg is_erase;
    reg is_prog;
    reg is_nvreg;
    always @* begin
        is_erase = 1'b0;
        is_prog = 1'b0;
        is_nvreg = 1'b0;
        case (cmd_opcode)
            8'h81, 8'hdb, 8'h20, 8'h52, 8'hd8,
            8'h60, 8'hc7: is_erase = 1'b1; // R11
            8'h02, 8'ha2, 8'h32, 8'had, 8'haf,
            8'h88, 8'h0a: is_prog = 1'b1; // R19
            8'h9b, 8'h01, 8'h31, 8'h11, 8'h71,
            8'h6f: begin
                is_prog = 1'b1; // R20
                is_nvreg = 1'b1;
            end
            default: begin
                is_prog = 1'b0; // R21
            end
        endcase
    end

    // ----------------------------------------
    // Operation state
    // ----------------------------------------
    localparam ST_IDLE = 2'b00;
    localparam ST_ERASE = 2'b01;
    localparam ST_PROG = 2'b10;

    reg [1:0] state_q;
    reg [1:0] state_d;
    reg nvreg_q;
    reg nvreg_d;
    reg eheld_q;
    reg eheld_d;
    reg pheld_q;
    reg pheld_d;
    reg efault_q;
    reg efault_d;
    reg pfault_q;
    reg pfault_d;
    reg lpd_q;
    reg lpd_d;
    reg upd_q;
    reg upd_d;
    reg pdsel_q;
    reg pdsel_d;
    reg int_reset;
    reg e_set;
    reg p_set;
    reg e_clr;
    reg p_clr;

    wire cmd = cmd_valid;
    wire running = (state_q != ST_IDLE);
    wire in_pd = lpd_q | upd_q;
    wire op_suspend_summary_flag = cmd & ((cmd_opcode == `FSES_OP_SUSPEND_A) |
        (cmd_opcode == `FSES_OP_SUSPEND_B));
    wire op_res = cmd & ((cmd_opcode == `FSES_OP_RESUME_A) |
        (cmd_opcode == `FSES_OP_RESUME_B));
    wire op_term = cmd & (cmd_opcode == `FSES_OP_TERMINATE);

    // Software writes to the select bit, taken from the bus below
    wire sw_pdsel_we;
    wire sw_pdsel_val;

    always @* begin
        state_d = state_q;
        nvreg_d = nvreg_q;
        eheld_d = eheld_q;
        pheld_d = pheld_q;
        lpd_d = lpd_q;
        upd_d = upd_q;
        pdsel_d = sw_pdsel_we ? sw_pdsel_val : pdsel_q;
        int_reset = 1'b0;
        e_set = 1'b0;
        p_set = 1'b0;
        e_clr = 1'b0;
        p_clr = 1'b0;
        // Errors reported by the array engine while executing
        if (op_error && state_q == ST_ERASE)
            e_set = 1'b1; // R9
        if (op_error && state_q == ST_PROG)
            p_set = 1'b1; // R10
        if (in_pd) begin
            // Only the exit command is honoured in power-down
            if (cmd && cmd_opcode == `FSES_OP_PDEXIT) begin
                lpd_d = 1'b0; // R17
                if (upd_q)
                    int_reset = 1'b1; // R18
                upd_d = 1'b0;
            end
        end else if (running) begin
            if (op_done) begin
                // Held flag of a resumed op drops at completion
                if (state_q == ST_PROG)
                    pheld_d = 1'b0; // R5
                else
                    eheld_d = 1'b0; // R5
                state_d = ST_IDLE;
            end else if (op_term && !nvreg_q) begin
                // Terminated op cannot resume, so its hold is dropped
                if (state_q == ST_ERASE) begin
                    e_set = 1'b1; // R15
                    eheld_d = 1'b0;
                end else begin
                    p_set = 1'b1; // R15
                    pheld_d = 1'b0;
                end
                state_d = ST_IDLE;
            end else if (op_suspend_summary_flag && !nvreg_q) begin // R24
                if (state_q == ST_ERASE)
                    eheld_d = 1'b1; // R2
                else
                    pheld_d = 1'b1; // R3
                state_d = ST_IDLE; // R13
            end
        end else if (cmd) begin
            // Suspend and terminate while idle fall through unhandled
            if (op_res) begin
                // Program resumes before a suspended erase
                if (pheld_q)
                    state_d = ST_PROG; // R7
                else if (eheld_q)
                    state_d = ST_ERASE; // R14
                nvreg_d = 1'b0;
            end else if (is_erase && !pheld_q && !eheld_q) begin
                e_clr = 1'b1; // R11
                state_d = ST_ERASE;
                nvreg_d = 1'b0;
            end else if (is_prog && !pheld_q) begin
                // Allowed with an erase held: nested program
                p_clr = 1'b1; // R12
                state_d = ST_PROG; // R7
                nvreg_d = is_nvreg;
            end else if (cmd_opcode == `FSES_OP_PDOWN) begin
                lpd_d = pdsel_q; // R23
                upd_d = ~pdsel_q; // R23
            end else if (cmd_opcode == `FSES_OP_UPDOWN) begin
                upd_d = 1'b1;
            end
        end
        // Erase while a program is held is refused above
        // Set wins over clear
        efault_d = e_set | (efault_q & ~e_clr);
        pfault_d = p_set | (pfault_q & ~p_clr);
        if (int_reset) begin
            state_d = ST_IDLE;
            eheld_d = 1'b0;
            pheld_d = 1'b0;
            efault_d = 1'b0; // R18
            pfault_d = 1'b0; // R18
            pdsel_d = `FSES_PDSEL_RST;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn || (ce && dev_reset)) begin
            // Every reset flavour clears the volatile flags
            state_q <= ST_IDLE;
            nvreg_q <= 1'b0;
            eheld_q <= 1'b0;
            pheld_q <= 1'b0;
            efault_q <= 1'b0; // R16
            pfault_q <= 1'b0; // R16
            lpd_q <= 1'b0;
            upd_q <= 1'b0;
            pdsel_q <= `FSES_PDSEL_RST;
        end else if (ce) begin
            state_q <= state_d;
            nvreg_q <= nvreg_d;
            eheld_q <= eheld_d;
            pheld_q <= pheld_d;
            efault_q <= efault_d;
            pfault_q <= pfault_d;
            lpd_q <= lpd_d;
            upd_q <= upd_d;
            pdsel_q <= pdsel_d;
        end
    end

    // ----------------------------------------
    // Registered status outputs
    // ----------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            busy_q <= 1'b0;
            suspend_summary_flag <= 1'b0;
            erase_held_flag <= 1'b0;
            program_held_flag <= 1'b0;
            erase_fault_flag <= 1'b0;
            program_fault_flag <= 1'b0;
            light_power_down_state <= 1'b0;
            ultra_power_down_state <= 1'b0;
        end else if (ce) begin
            // Mirrors lag the state by one cycle
            busy_q <= running;
            suspend_summary_flag <= eheld_q | pheld_q; // R4
            erase_held_flag <= eheld_q; // R6
            program_held_flag <= pheld_q; // R6
            erase_fault_flag <= efault_q;
            program_fault_flag <= pfault_q;
            light_power_down_state <= lpd_q;
            ultra_power_down_state <= upd_q;
        end
    end

    // ----------------------------------------
    // AXI4-Lite write path
    // ----------------------------------------
    reg aw_got_q;
    reg w_got_q;
    reg [ADDR_W-1:0] waddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    wire aw_hs = s_axi_awvalid & s_axi_awready;
    wire w_hs = s_axi_wvalid & s_axi_wready;
    wire do_wr = aw_got_q & w_got_q & ~s_axi_bvalid;
    wire wr_sr4 = (waddr_q[3:2] == 2'd1);
    wire wr_hit = (waddr_q[1:0] == 2'b00) & (waddr_q[3:2] != 2'd3);

    // Only the select bit is writable; others are hardware owned
    assign sw_pdsel_we = do_wr & wr_sr4 & wstrb_q[0];
    assign sw_pdsel_val = wdata_q[`FSES_SR4_PDSEL];

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            waddr_q <= {ADDR_W{1'b0}};
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `FSES_RESP_OKAY;
        end else if (ce) begin
            if (aw_hs) begin
                aw_got_q <= 1'b1;
                waddr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end else if (!aw_got_q && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
            end
            if (w_hs) begin
                w_got_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end else if (!w_got_q && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
            end
            if (do_wr) begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `FSES_RESP_OKAY
                                      : `FSES_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // AXI4-Lite read path
    // ----------------------------------------
    reg [31:0] rd_mux;
    reg rd_hit;
    always @* begin
        rd_mux = 32'h0000_0000;
        rd_hit = (s_axi_araddr[1:0] == 2'b00);
        case (s_axi_araddr[3:0])
            `FSES_OFF_SR2:
                rd_mux[`FSES_SR2_SUSPEND_SUMMARY_FLAG] = eheld_q | pheld_q; // R1
            `FSES_OFF_SR4: begin
                rd_mux[`FSES_SR4_EFLT] = efault_q; // R9
                rd_mux[`FSES_SR4_PFLT] = pfault_q; // R10
                rd_mux[`FSES_SR4_PDSEL] = pdsel_q;
            end
            `FSES_OFF_SR5: begin
                rd_mux[`FSES_SR5_EHELD] = eheld_q; // R2
                rd_mux[`FSES_SR5_PHELD] = pheld_q; // R3
            end
            `FSES_OFF_STATE: begin
                rd_mux[`FSES_ST_BUSY] = running;
                rd_mux[`FSES_ST_ERUN] = (state_q == ST_ERASE);
                rd_mux[`FSES_ST_LPD] = lpd_q;
                rd_mux[`FSES_ST_UPD] = upd_q;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `FSES_RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= rd_hit ? `FSES_RESP_OKAY
                                      : `FSES_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end else if (!s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule

/* src/fses_regs.vh */
// Register map, field positions and opcodes of the suspend/fault tracker
// Operation
// (R1) Summary flag sits at bit 7 of status 2; set while anything suspended.
// (R2) Erase-held flag at bit 3 of status 5, set when erase suspends.
// (R3) Program-held flag at bit 2 of status 5, set when program suspends.
// (R4) Summary equals erase-held OR program-held at all times.
// (R5) Held flag clears when the resumed operation of that kind completes.
// (R6) Summary,erase,program read 000, 101, 110 or 111 only.
// (R7) Program allowed while erase suspended; program resumes and ends first.
// (R8) Host never starts an erase while a program is suspended.
// (R9) Erase-fault flag at bit 4 of status 4, set on erase error.
// (R10) Program-fault flag at bit 5 of status 4, set on program error.
// (R11) Accepting a block or chip erase clears the erase-fault flag.
// (R12) Accepting program, register write or lock clears program-fault flag.
// (R13) Fault flags keep their value while an operation is suspended.
// (R14) Resume leaves both fault flags unchanged.
// (R15) Terminate during execution sets the fault flag of that operation; the code ignores it while a register write or lock runs.
// (R16) Every device reset clears both fault flags.
// (R17) Leaving light power-down leaves fault flags unchanged.
// (R18) Leaving ultra power-down resets the device and clears fault flags.
// (R19) Page program without erase and read-modify-write errors set program.
// (R20) Indirect status register write errors set the program-fault flag.
// (R21) Status register reads never set either fault flag.
// (R22) Host polls fault flags after each program or erase.
// (R23) Power-down enters light state with select bit set, else ultra.
// (R24) Suspend accepted only while executing; otherwise ignored.
`ifndef FSES_REGS_VH
`define FSES_REGS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define FSES_OFF_SR2 4'h0
`define FSES_OFF_SR4 4'h4
`define FSES_OFF_SR5 4'h8
`define FSES_OFF_STATE 4'hc

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FSES_SR2_SUSPEND_SUMMARY_FLAG 7
`define FSES_SR4_EFLT 4
`define FSES_SR4_PFLT 5
`define FSES_SR4_PDSEL 7
`define FSES_SR5_EHELD 3
`define FSES_SR5_PHELD 2
`define FSES_ST_BUSY 0
`define FSES_ST_ERUN 1
`define FSES_ST_LPD 2
`define FSES_ST_UPD 3

// ----------------------------------------
// Reset values and bus answers
// ----------------------------------------
`define FSES_PDSEL_RST 1'b0
`define FSES_RESP_OKAY 2'b00
`define FSES_RESP_SLVERR 2'b10

// ----------------------------------------
// Command codes
// ----------------------------------------
`define FSES_OP_SUSPEND_A 8'h75
`define FSES_OP_SUSPEND_B 8'hb0
`define FSES_OP_RESUME_A 8'hd0
`define FSES_OP_RESUME_B 8'h7a
`define FSES_OP_TERMINATE 8'hf0
`define FSES_OP_PDOWN 8'hb9
`define FSES_OP_UPDOWN 8'h79
`define FSES_OP_PDEXIT 8'hab

`endif

/* tb/fses_sva.sv */
// Checker of suspend and fault flag behaviour at the tracker pins
module fses_sva (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    input wire ce,
    // Commands and engine events
    input wire cmd_valid,
    input wire [7:0] cmd_opcode,
    input wire op_done,
    input wire op_error,
    input wire dev_reset,
    // Status pins
    input wire busy_q,
    input wire suspend_summary_flag,
    input wire erase_held_flag,
    input wire program_held_flag,
    input wire erase_fault_flag,
    input wire program_fault_flag,
    input wire light_power_down_state,
    input wire ultra_power_down_state
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    wire [1:0] flt = {erase_fault_flag, program_fault_flag};
    wire cmd = ce && cmd_valid && !op_error && !dev_reset;
    wire [7:0] op = cmd_opcode;
    // Pins lag two edges, so a quiet cycle before is needed
    sequence s_calm;
        !$past(cmd_valid) && !$past(op_done) && !$past(op_error)
            && !$past(dev_reset);
    endsequence
    sequence s_idle;
        s_calm ##0 (!busy_q && !suspend_summary_flag
            && !light_power_down_state && !ultra_power_down_state);
    endsequence
    sequence s_erase;
        cmd && op inside {8'h81, 8'hdb, 8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7};
    endsequence
    sequence s_prog;
        cmd && op inside {8'h02, 8'ha2, 8'h32, 8'had, 8'haf, 8'h88, 8'h0a};
    endsequence
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    property p_sum;
        suspend_summary_flag == (erase_held_flag || program_held_flag);
    endproperty
    property p_er_clr;
        s_idle ##0 s_erase |-> ##2 !erase_fault_flag;
    endproperty
    property p_pg_clr;
        s_idle ##0 s_prog |-> ##2 !program_fault_flag;
    endproperty
    property p_resume;
        cmd && op inside {8'hd0, 8'h7a} |-> ##2 $stable(flt);
    endproperty
    property p_sread;
        cmd && op inside {8'h05, 8'h35, 8'h15, 8'h65} |-> ##2 $stable(flt);
    endproperty
    property p_lpd;
        s_calm ##0 (cmd && op == 8'hab && light_power_down_state)
            |-> ##2 $stable(flt);
    endproperty
    property p_upd;
        s_calm ##0 (cmd && op == 8'hab && ultra_power_down_state)
            |-> ##2 flt == 2'h0;
    endproperty
    property p_rst;
        ce && dev_reset |-> ##2 flt == 2'h0;
    endproperty
    property p_held;
        $rose(erase_held_flag) || $rose(program_held_flag)
            |-> $past(cmd_valid, 2)
            && $past(cmd_opcode, 2) inside {8'h75, 8'hb0};
    endproperty
    property p_fall;
        $fell(program_held_flag)
            |-> $past(op_done, 2) || $past(cmd_valid, 2)
            || $past(dev_reset, 2);
    endproperty
    a_sum: assert property (p_sum)
        else $error("summary flag differs from held flags");
    a_er_clr: assert property (p_er_clr)
        else $error("erase fault kept after erase start");
    a_pg_clr: assert property (p_pg_clr)
        else $error("program fault kept after program start");
    a_resume: assert property (p_resume)
        else $error("resume changed a fault flag");
    a_sread: assert property (p_sread)
        else $error("status read changed a fault flag");
    a_lpd: assert property (p_lpd)
        else $error("light exit changed a fault flag");
    a_upd: assert property (p_upd)
        else $error("ultra exit kept a fault flag");
    a_rst: assert property (p_rst)
        else $error("device reset kept a fault flag");
    a_held: assert property (p_held)
        else $error("held flag rose without suspend");
    a_fall: assert property (p_fall)
        else $error("program held flag fell without cause");
endmodule

/* tb/fses_host.sv */
// Host side model issuing commands and engine events
module fses_host (
    // Clock
    input wire aclk,
    // Status seen by the host
    input wire program_held_flag,
    // Command and event lines
    output logic cmd_valid,
    output logic [7:0] cmd_opcode,
    output logic op_done,
    output logic op_error,
    output logic dev_reset
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        cmd_valid = 1'b0;
        cmd_opcode = 8'h00;
        op_done = 1'b0;
        op_error = 1'b0;
        dev_reset = 1'b0;
    end
    task automatic cmd(input logic [7:0] c);
        // Nesting only erase first, so no erase over a held program
        if (program_held_flag && c inside {8'h81, 8'hdb, 8'h20, 8'h52,
            8'hd8, 8'h60, 8'hc7}) return;
        @(posedge aclk);
        cmd_valid <= 1'b1;
        cmd_opcode <= c;
        @(posedge aclk);
        cmd_valid <= 1'b0;
        cmd_opcode <= ~c;
    endtask
    task automatic pulse(input int k);
        @(posedge aclk);
        op_done <= (k == 0);
        op_error <= (k == 1);
        dev_reset <= (k == 2);
        @(posedge aclk);
        op_done <= 1'b0;
        op_error <= 1'b0;
        dev_reset <= 1'b0;
    endtask
endmodule

/* tb/fses_tb_top.sv */
// Top testbench of the suspend and fault flag tracker
`include "fses_regs.vh"
module fses_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk, aresetn, ce, sel;
    logic awvalid, wvalid, bready, arvalid, rready;
    wire awready, wready, bvalid, arready, rvalid;
    logic [3:0] awaddr, araddr, wstrb;
    logic [31:0] wdata;
    wire [31:0] rdata;
    wire [1:0] bresp, rresp;
    wire cmd_valid, op_done, op_error, dev_reset;
    wire [7:0] cmd_opcode, pins;
    logic [37:0] rq[$];
    logic [1:0] wq[$];
    logic [15:0] lfsr;
    int err_count = 0;
    int n_compared = 0;
    fses_top u_dut (
        .aclk(aclk), .aresetn(aresetn), .ce(ce),
        .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode),
        .op_done(op_done), .op_error(op_error), .dev_reset(dev_reset),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .busy_q(pins[0]), .suspend_summary_flag(pins[7]),
        .erase_held_flag(pins[6]), .program_held_flag(pins[5]),
        .erase_fault_flag(pins[4]), .program_fault_flag(pins[3]),
        .light_power_down_state(pins[1]), .ultra_power_down_state(pins[2])
    );
    fses_host u_host (
        .aclk(aclk), .program_held_flag(pins[5]), .cmd_valid(cmd_valid),
        .cmd_opcode(cmd_opcode), .op_done(op_done), .op_error(op_error),
        .dev_reset(dev_reset)
    );
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    function automatic logic [15:0] step(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    task automatic miss(input string s);
        err_count++;
        $display("mismatch at %0t: %s", $time, s);
    endtask
    task automatic final_report;
        if (err_count == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Bus master and expectations
    // ----------------------------------------
    task automatic wr(input logic [3:0] a, input logic [31:0] d,
        input logic [3:0] s);
        wq.push_back((a[1:0] != 0 || a == 4'hc) ? 2'h2 : 2'h0);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!(bvalid && bready));
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        rq.push_back({(a[1:0] != 0) ? 2'h2 : 2'h0, a, e});
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!(rvalid && rready));
        rready <= 1'b0;
    endtask
    // Only documented bits are compared; the rest are left open
    always @(posedge aclk) begin
        logic [37:0] x;
        logic [7:0] m;
        if (bvalid && bready) begin
            n_compared++;
            if (bresp !== wq.pop_front()) miss("write response");
        end
        if (rvalid && rready) begin
            x = rq.pop_front();
            m = x[35:32] == 0 ? 8'h80 : x[35:32] == 4 ? 8'hb0 :
                x[35:32] == 8 ? 8'h0c : x[35:32] == 12 ? 8'h0f : 8'h00;
            n_compared++;
            if (rresp !== x[37:36] || ((rdata[7:0] ^ x[7:0]) & m) !== 0)
                miss("read data");
        end
    end
    // v holds held e/p, fault e/p, ultra, light, erase running, busy
    task automatic ex(input logic [7:0] v);
        rd(`FSES_OFF_SR2, {24'h0, v[7] | v[6], 7'h0});
        rd(`FSES_OFF_SR4, {24'h0, sel, 1'b0, v[4], v[5], 4'h0});
        rd(`FSES_OFF_SR5, {28'h0, v[7], v[6], 2'h0});
        rd(`FSES_OFF_STATE, {28'h0, v[3:0]});
        n_compared++;
        if (pins !== {v[7] | v[6], v[7:2], v[0]}) miss("status pins");
    endtask
    task automatic ev(input int k);
        lfsr = step(lfsr);
        repeat (lfsr[1:0]) @(posedge aclk);
        u_host.pulse(k);
    endtask
    task automatic set_sel(input logic s);
        sel = s;
        lfsr = step(lfsr);
        wr(`FSES_OFF_SR4, {lfsr, lfsr[15:8], s, lfsr[6:0]},
            {lfsr[3:1], 1'b1});
        wr(`FSES_OFF_SR4, {24'h0, ~s, 7'h0}, {lfsr[3:1], 1'b0});
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        err_count++;
        final_report;
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        logic [7:0] er[7];
        logic [7:0] pg[13];
        logic [7:0] sr[4];
        er = '{8'h81, 8'hdb, 8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7};
        pg = '{8'h02, 8'ha2, 8'h32, 8'had, 8'haf, 8'h88, 8'h0a, 8'h9b,
            8'h01, 8'h31, 8'h11, 8'h71, 8'h6f};
        sr = '{8'h05, 8'h35, 8'h15, 8'h65};
        lfsr = 16'hdd65;
        {aresetn, ce, sel, awvalid, wvalid, bready} = 6'h10;
        {arvalid, rready, awaddr, araddr, wstrb} = 14'h000f;
        wdata = 32'h0000_0000;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        wr(`FSES_OFF_STATE, {lfsr, lfsr}, lfsr[3:0]);
        rd(4'h2, 32'h0000_0000);
        ex(8'h00);
        foreach (er[i]) begin
            u_host.cmd(er[i]);
            ex(8'h03);
            ev(1);
            ev(0);
            ex(8'h20);
        end
        foreach (pg[i]) begin
            u_host.cmd(pg[i]);
            ex(8'h21);
            ev(1);
            ev(0);
            ex(8'h30);
        end
        foreach (sr[i]) begin
            u_host.cmd(sr[i]);
            ex(8'h30);
        end
        ce <= 1'b0;
        u_host.cmd(er[lfsr[2:0] % 7]);
        ce <= 1'b1;
        ex(8'h30);
        u_host.cmd(8'h75);
        ex(8'h30);
        u_host.cmd(8'h60);
        ex(8'h13);
        u_host.cmd(8'h75);
        ex(8'h90);
        u_host.cmd(8'h02);
        ex(8'h81);
        u_host.cmd(8'hb0);
        ex(8'hc0);
        u_host.cmd(8'hd0);
        ex(8'hc1);
        ev(1);
        ev(0);
        ex(8'h90);
        u_host.cmd(8'h7a);
        ex(8'h93);
        ev(0);
        ex(8'h10);
        u_host.cmd(8'h20);
        u_host.cmd(8'hf0);
        ex(8'h30);
        u_host.cmd(8'h02);
        ex(8'h21);
        u_host.cmd(8'hf0);
        ex(8'h30);
        set_sel(1'b1);
        u_host.cmd(8'hb9);
        ex(8'h34);
        u_host.cmd(8'hab);
        ex(8'h30);
        set_sel(1'b0);
        u_host.cmd(8'hb9);
        ex(8'h38);
        u_host.cmd(8'hab);
        ex(8'h00);
        u_host.cmd(8'h02);
        u_host.cmd(8'hf0);
        u_host.cmd(8'h79);
        ex(8'h18);
        ev(2);
        ex(8'h00);
        u_host.cmd(8'h20);
        ev(1);
        ex(8'h23);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        ex(8'h00);
        final_report;
    end
endmodule
bind fses_top fses_sva u_sva (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .cmd_valid(cmd_valid),
    .cmd_opcode(cmd_opcode), .op_done(op_done), .op_error(op_error),
    .dev_reset(dev_reset), .busy_q(busy_q),
    .suspend_summary_flag(suspend_summary_flag),
    .erase_held_flag(erase_held_flag), .program_held_flag(program_held_flag),
    .erase_fault_flag(erase_fault_flag),
    .program_fault_flag(program_fault_flag),
    .light_power_down_state(light_power_down_state),
    .ultra_power_down_state(ultra_power_down_state)
);
